// ==== mfh_pkg.sv ====
// Constants, register map and micro encodings for the micro fetch/hold control.
package mfh_pkg;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_LATCH = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_MAR = 8'h0C;
	localparam logic [7:0] REG_TAPE = 8'h10;
	localparam logic [7:0] REG_MICRO = 8'h14;
	localparam int CTRL_TAPE_SRC = 0;
	localparam int CTRL_LOAD_MODE = 1;
	localparam int CTRL_ASM_DIS = 2;
	localparam int CTRL_HALT_REQ = 3;
	localparam int CTRL_SW_CLEAR = 4;
	localparam logic [3:0] CTRL_RESET = 4'h0;
	localparam int ST_HOLD = 0;
	localparam int ST_FULL = 1;
	localparam int ST_STORED = 2;
	localparam int ST_HALTED = 3;
	localparam int ST_REFRESH = 4;
	localparam int ST_SKIP = 5;
	localparam int ST_NO_JUMP = 6;
	localparam int ST_CLEAR_PEND = 7;
	localparam int TAPE_CNT_LSB = 24;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;
	localparam logic [15:0] MICRO_NOP = 16'h0000;
	localparam logic [15:0] MICRO_RESET = 16'h0000;
	localparam logic [7:0] MANIP_OP = 8'h3C;
	localparam logic [1:0] VAR_INC_TEST = 2'h1;
	localparam logic [1:0] VAR_DEC_TEST = 2'h2;
	localparam logic [3:0] MICRO_JUMP_CLASS = 4'hA;
	localparam logic [3:0] MICRO_MOVE_CLASS = 4'h1;
	localparam logic [3:0] MICRO_SINK_M = 4'h5;
	localparam logic [23:0] MAR_RESET = 24'h000000;
	localparam logic [23:0] MAR_STEP = 24'h000010;
	localparam logic [23:0] MAR_SKIP_STEP = 24'h000020;
	localparam logic [31:0] LATCH_RESET = 32'h00000000;
	localparam int KBA_LO = 3;
	localparam int KBA_HI = 18;
	localparam int HALF_SEL_BIT = 4;
	localparam logic [4:0] ASM_FULL_COUNT = 5'h18;
	localparam logic [1:0] TO_PHASE = 2'h0;
	localparam logic [1:0] STEP_PULSE_CYCLES = 2'h2;
endpackage : mfh_pkg

// ==== mfh_sync2.sv ====
// Two-stage synchroniser for inputs from outside the system clock domain.
`timescale 1ns/1ps
module mfh_sync2 #(
	parameter int W = 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule : mfh_sync2

// ==== mfh_step_pulse.sv ====
// One-shot step-address pulse generator for the console increment button.
`timescale 1ns/1ps
module mfh_step_pulse (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic step_button_pressed,
	input wire logic enable,
	output logic step_address_pulse
);
	logic step_button_released;
	logic [1:0] cnt;

	assign step_button_released = ~step_button_pressed;

	// The count saturates at three, so a held button never retriggers.
	always_ff @(posedge aclk) begin
		if (!aresetn || step_button_released) begin
			cnt <= 2'h0;
		end else if (cnt == 2'h0) begin
			if (enable) begin
				cnt <= 2'h1;
			end
		end else if (cnt != 2'h3) begin
			cnt <= cnt + 2'h1;
		end
	end

	assign step_address_pulse = (cnt != 2'h0) &&
		(cnt <= mfh_pkg::STEP_PULSE_CYCLES);
endmodule : mfh_step_pulse

// ==== mfh_core.sv ====
// Micro fetch/hold control with tape assembly, console step and clear.
`timescale 1ns/1ps
module mfh_core (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic micro_finish,
	input wire logic arith_overflow,
	input wire logic arith_underflow,
	input wire logic refresh_request,
	input wire logic tape_clock,
	input wire logic tape_serial_bit,
	input wire logic step_button_pressed,
	input wire logic clear_button,
	output logic [15:0] micro_bus,
	output logic hold_flag_clear,
	output logic next_micro_fetch_enable,
	output logic assembly_not_full,
	output logic incoming_bit_stored,
	output logic incoming_bit_shift_in,
	output logic incdec_test_decode,
	output logic skip_next_micro,
	output logic step_address_pulse,
	output logic clear_inhibit,
	output logic general_processor_clear,
	output logic refresh_granted,
	output logic hold_refresh_demand,
	output logic no_jump,
	output logic halted,
	output logic [15:0] key_byte_address_bits,
	output logic micro_half_select
);
	logic tclk_s;
	logic tbit_s;
	logic step_s;
	logic clrbtn_s;
	logic tclk_d;
	logic clrbtn_d;
	logic aw_held;
	logic w_held;
	logic wr_fire;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_mapped;
	logic [31:0] rd_word;
	logic rd_mapped;
	logic [3:0] ctrl_reg;
	logic sw_clear;
	logic [31:0] micro_word_latch;
	logic [23:0] micro_address_register;
	logic [23:0] next_micro_address;
	logic [15:0] micro_reg;
	logic hold;
	logic skip_pending;
	logic micro_address_upcount;
	logic sink_is_m;
	logic clear_pending;
	logic [1:0] phase;
	logic bit_timing_phase;
	logic bit_taken;
	logic asm_shift;
	logic [23:0] asm_reg;
	logic [4:0] asm_count;
	logic asm_full;
	logic tape_wr;
	logic step_pulse_d;

	mfh_sync2 #(
		.W(4)
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d({tape_clock, tape_serial_bit, step_button_pressed, clear_button}),
		.q({tclk_s, tbit_s, step_s, clrbtn_s})
	);

	mfh_step_pulse u_step (
		.aclk(aclk),
		.aresetn(aresetn),
		.step_button_pressed(step_s),
		.enable(halted),
		.step_address_pulse(step_address_pulse)
	);

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// Write channel: address and data are taken independently, in any order.
	assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
	assign s_axi_wready = ~w_held & ~s_axi_bvalid;
	assign wr_fire = aw_held & w_held & ~s_axi_bvalid;
	assign wr_mapped = (wr_addr == mfh_pkg::REG_CTRL) ||
		(wr_addr == mfh_pkg::REG_LATCH) || (wr_addr == mfh_pkg::REG_STATUS) ||
		(wr_addr == mfh_pkg::REG_MAR) || (wr_addr == mfh_pkg::REG_TAPE) ||
		(wr_addr == mfh_pkg::REG_MICRO);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			wr_addr <= 8'h00;
		end else if (wr_fire) begin
			aw_held <= 1'b0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			wr_addr <= s_axi_awaddr;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			wr_data <= 32'h00000000;
			wr_strb <= 4'h0;
		end else if (wr_fire) begin
			w_held <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			wr_data <= s_axi_wdata;
			wr_strb <= s_axi_wstrb;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= mfh_pkg::AXI_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_mapped ? mfh_pkg::AXI_OKAY : mfh_pkg::AXI_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Read channel: one read at a time, answered the cycle after it is taken.
	assign s_axi_arready = ~s_axi_rvalid;

	always_comb begin
		rd_word = 32'h00000000;
		rd_mapped = 1'b1;
		case (s_axi_araddr)
			mfh_pkg::REG_CTRL: rd_word = {28'h0000000, ctrl_reg};
			mfh_pkg::REG_LATCH: rd_word = micro_word_latch;
			mfh_pkg::REG_STATUS: begin
				rd_word[mfh_pkg::ST_HOLD] = hold;
				rd_word[mfh_pkg::ST_FULL] = asm_full;
				rd_word[mfh_pkg::ST_STORED] = incoming_bit_stored;
				rd_word[mfh_pkg::ST_HALTED] = halted;
				rd_word[mfh_pkg::ST_REFRESH] = refresh_granted;
				rd_word[mfh_pkg::ST_SKIP] = skip_pending;
				rd_word[mfh_pkg::ST_NO_JUMP] = no_jump;
				rd_word[mfh_pkg::ST_CLEAR_PEND] = clear_pending;
			end
			mfh_pkg::REG_MAR: rd_word = {8'h00, micro_address_register};
			mfh_pkg::REG_TAPE: begin
				rd_word[23:0] = asm_reg;
				rd_word[mfh_pkg::TAPE_CNT_LSB +: 5] = asm_count;
			end
			mfh_pkg::REG_MICRO: rd_word = {16'h0000, micro_reg};
			default: rd_mapped = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= mfh_pkg::AXI_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_mapped ? mfh_pkg::AXI_OKAY : mfh_pkg::AXI_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Control register; the software clear bit is a write-one pulse.
	assign sw_clear = wr_fire && (wr_addr == mfh_pkg::REG_CTRL) &&
		wr_strb[0] && wr_data[mfh_pkg::CTRL_SW_CLEAR];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= mfh_pkg::CTRL_RESET;
		end else if (wr_fire && (wr_addr == mfh_pkg::REG_CTRL) && wr_strb[0]) begin
			ctrl_reg <= wr_data[3:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			micro_word_latch <= mfh_pkg::LATCH_RESET;
		end else if (wr_fire && (wr_addr == mfh_pkg::REG_LATCH)) begin
			micro_word_latch <= merge(micro_word_latch, wr_data, wr_strb);
		end
	end

	// Hold flag follows the tape source selection in run or load mode.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hold <= 1'b0;
		end else begin
			hold <= ctrl_reg[mfh_pkg::CTRL_TAPE_SRC] &
				(~halted | ctrl_reg[mfh_pkg::CTRL_LOAD_MODE]);
		end
	end
	assign hold_flag_clear = ~hold;

	// Micro decode on the executing micro.
	assign incdec_test_decode = hold_flag_clear &&
		(micro_reg[15:8] == mfh_pkg::MANIP_OP) &&
		((micro_reg[1:0] == mfh_pkg::VAR_INC_TEST) ||
		(micro_reg[1:0] == mfh_pkg::VAR_DEC_TEST));
	assign sink_is_m = hold_flag_clear &&
		(micro_reg[15:12] == mfh_pkg::MICRO_MOVE_CLASS) &&
		(micro_reg[3:0] == mfh_pkg::MICRO_SINK_M);
	assign no_jump = ~(hold_flag_clear &&
		(micro_reg[15:12] == mfh_pkg::MICRO_JUMP_CLASS)) & ~skip_pending;
	assign skip_next_micro = skip_pending;

	assign next_micro_fetch_enable = hold_flag_clear & assembly_not_full &
		micro_finish & ~halted;
	// Address moves with the fetch except while a refresh is granted, when only the fetch runs.
	assign micro_address_upcount = micro_finish & ~refresh_granted &
		hold_flag_clear & ~halted & assembly_not_full;

	// Address advance: software load first, then step, then upcount.
	always_comb begin
		next_micro_address = micro_address_register;
		if (wr_fire && (wr_addr == mfh_pkg::REG_MAR)) begin
			next_micro_address = 24'(merge(
				{8'h00, micro_address_register}, wr_data, wr_strb));
		end else if (step_address_pulse && !step_pulse_d) begin
			next_micro_address = micro_address_register + mfh_pkg::MAR_STEP;
		end else if (micro_address_upcount) begin
			next_micro_address = micro_address_register +
				(skip_pending ? mfh_pkg::MAR_SKIP_STEP : mfh_pkg::MAR_STEP);
		end
	end

	// The step pulse spans two clocks; only its first clock moves the address.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			step_pulse_d <= 1'b0;
		end else begin
			step_pulse_d <= step_address_pulse;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || general_processor_clear) begin
			micro_address_register <= mfh_pkg::MAR_RESET;
		end else begin
			micro_address_register <= next_micro_address;
		end
	end
	assign key_byte_address_bits =
		micro_address_register[mfh_pkg::KBA_HI:mfh_pkg::KBA_LO];
	assign micro_half_select = micro_address_register[mfh_pkg::HALF_SEL_BIT];

	// The micro register keeps its micro while held; the fetch loads it.
	always_ff @(posedge aclk) begin
		if (!aresetn || general_processor_clear) begin
			micro_reg <= mfh_pkg::MICRO_RESET;
		end else if (next_micro_fetch_enable) begin
			micro_reg <= next_micro_address[mfh_pkg::HALF_SEL_BIT] ?
				micro_word_latch[31:16] : micro_word_latch[15:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			micro_bus <= mfh_pkg::MICRO_NOP;
		end else if (hold) begin
			micro_bus <= mfh_pkg::MICRO_NOP;
		end else begin
			micro_bus <= micro_reg;
		end
	end

	// A skip is armed at finish and spent by the next upcount.
	always_ff @(posedge aclk) begin
		if (!aresetn || general_processor_clear) begin
			skip_pending <= 1'b0;
		end else if (incdec_test_decode && micro_finish &&
			(arith_overflow || arith_underflow)) begin
			skip_pending <= 1'b1;
		end else if (micro_address_upcount) begin
			skip_pending <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			halted <= 1'b0;
		end else if (!ctrl_reg[mfh_pkg::CTRL_HALT_REQ]) begin
			halted <= 1'b0;
		end else if (no_jump && micro_finish) begin
			halted <= 1'b1;
		end
	end

	assign hold_refresh_demand = ~(sink_is_m | ~no_jump |
		(ctrl_reg[mfh_pkg::CTRL_HALT_REQ] & ~halted));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			refresh_granted <= 1'b0;
		end else if (refresh_request && micro_finish && hold_refresh_demand) begin
			refresh_granted <= 1'b1;
		end else if (!refresh_request) begin
			refresh_granted <= 1'b0;
		end
	end

	// Clear requests wait while a refresh is granted, then fire once.
	assign clear_inhibit = refresh_granted;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clrbtn_d <= 1'b0;
			clear_pending <= 1'b0;
			general_processor_clear <= 1'b0;
		end else begin
			clrbtn_d <= clrbtn_s;
			general_processor_clear <= clear_pending & ~clear_inhibit;
			if (sw_clear || (clrbtn_s && !clrbtn_d)) begin
				clear_pending <= 1'b1;
			end else if (!clear_inhibit) begin
				clear_pending <= 1'b0;
			end
		end
	end

	// Bit timing phase runs free; one phase in four is the shift phase.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase <= 2'h0;
		end else begin
			phase <= phase + 2'h1;
		end
	end
	assign bit_timing_phase = (phase == mfh_pkg::TO_PHASE);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tclk_d <= 1'b0;
			incoming_bit_stored <= 1'b0;
		end else begin
			tclk_d <= tclk_s;
			if (tclk_s && tbit_s) begin
				incoming_bit_stored <= 1'b1;
			end else if (!tclk_s) begin
				incoming_bit_stored <= 1'b0;
			end
		end
	end

	assign incoming_bit_shift_in = incoming_bit_stored & bit_timing_phase &
		~ctrl_reg[mfh_pkg::CTRL_ASM_DIS];
	// The delayed tape clock stands for four clocks, a whole phase cycle,
	// and the stored bit is valid in all of them, so no bit is missed.
	assign asm_shift = tclk_d & ~bit_taken & bit_timing_phase &
		~ctrl_reg[mfh_pkg::CTRL_ASM_DIS] & ~asm_full;
	assign tape_wr = wr_fire && (wr_addr == mfh_pkg::REG_TAPE);
	assign assembly_not_full = ~asm_full;

	// One bit is assembled per tape clock pulse; a write empties the register.
	always_ff @(posedge aclk) begin
		if (!aresetn || general_processor_clear) begin
			bit_taken <= 1'b0;
			asm_reg <= 24'h000000;
			asm_count <= 5'h00;
			asm_full <= 1'b0;
		end else begin
			if (!tclk_s) begin
				bit_taken <= 1'b0;
			end else if (asm_shift) begin
				bit_taken <= 1'b1;
			end
			if (tape_wr) begin
				asm_reg <= 24'h000000;
				asm_count <= 5'h00;
				asm_full <= 1'b0;
			end else if (asm_shift) begin
				asm_reg <= {asm_reg[22:0], incoming_bit_shift_in};
				asm_count <= asm_count + 5'h01;
				asm_full <= (asm_count + 5'h01) == mfh_pkg::ASM_FULL_COUNT;
			end
		end
	end
endmodule : mfh_core

// ==== mfh_core_properties.sv ====
// Concurrent checks on the ports of the micro fetch/hold control.
`timescale 1ns/1ps
module mfh_core_properties (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic micro_finish,
	input wire logic arith_overflow,
	input wire logic arith_underflow,
	input wire logic refresh_request,
	input wire logic tape_clock,
	input wire logic [15:0] micro_bus,
	input wire logic hold_flag_clear,
	input wire logic next_micro_fetch_enable,
	input wire logic assembly_not_full,
	input wire logic incoming_bit_stored,
	input wire logic incoming_bit_shift_in,
	input wire logic incdec_test_decode,
	input wire logic skip_next_micro,
	input wire logic step_address_pulse,
	input wire logic clear_inhibit,
	input wire logic general_processor_clear,
	input wire logic refresh_granted,
	input wire logic hold_refresh_demand,
	input wire logic no_jump,
	input wire logic halted,
	input wire logic [15:0] key_byte_address_bits,
	input wire logic micro_half_select
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_fetch_gate: assert property (
		next_micro_fetch_enable == (hold_flag_clear && assembly_not_full
		&& micro_finish && !halted)) else $error("fetch gating wrong");
	a_hold_nop: assert property (
		!hold_flag_clear ##1 !hold_flag_clear |-> micro_bus == 16'h0000)
		else $error("micro bus not idle during hold");
	a_step_len: assert property (
		step_address_pulse [*2] |=> !step_address_pulse)
		else $error("step pulse longer than two clocks");
	a_step_halted: assert property (
		$rose(step_address_pulse) |-> halted) else $error("step while running");
	a_half_mirror: assert property (
		micro_half_select == key_byte_address_bits[1])
		else $error("half select differs from address bit");
	a_upcount_half: assert property (
		next_micro_fetch_enable && !refresh_granted && !refresh_request
		&& !skip_next_micro && !arith_overflow && !arith_underflow
		&& !general_processor_clear
		|=> micro_half_select != $past(micro_half_select))
		else $error("upcount did not toggle half select");
	a_clear_block: assert property (
		refresh_granted |=> !general_processor_clear)
		else $error("clear issued during refresh grant");
	a_inhibit_eq: assert property (
		clear_inhibit == refresh_granted) else $error("clear inhibit wrong");
	a_grant_finish: assert property (
		$rose(refresh_granted) |-> $past(micro_finish && refresh_request
		&& hold_refresh_demand)) else $error("refresh granted off finish");
	a_shift_stored: assert property (
		incoming_bit_shift_in |-> incoming_bit_stored)
		else $error("shift without stored bit");
	a_stored_drop: assert property (
		!tape_clock [*5] |-> !incoming_bit_stored)
		else $error("stored bit outlived tape clock");
	a_skip_cause: assert property (
		$rose(skip_next_micro) |-> $past(incdec_test_decode && micro_finish
		&& (arith_overflow || arith_underflow))) else $error("stray skip");
	a_halt_nojump: assert property (
		$rose(halted) |-> $past(no_jump && micro_finish))
		else $error("halt outside no-jump finish");
	c_step: cover property ($rose(step_address_pulse));
	c_skip: cover property ($rose(skip_next_micro));
	c_grant: cover property ($rose(refresh_granted));
	c_full: cover property ($fell(assembly_not_full));
endmodule : mfh_core_properties

bind mfh_core mfh_core_properties u_props (.aclk, .aresetn, .micro_finish,
	.arith_overflow, .arith_underflow, .refresh_request, .tape_clock,
	.micro_bus, .hold_flag_clear, .next_micro_fetch_enable,
	.assembly_not_full, .incoming_bit_stored, .incoming_bit_shift_in,
	.incdec_test_decode, .skip_next_micro, .step_address_pulse,
	.clear_inhibit, .general_processor_clear, .refresh_granted,
	.hold_refresh_demand, .no_jump, .halted, .key_byte_address_bits,
	.micro_half_select);

// ==== mfh_tape_model.sv ====
// Cassette drive model sending one frame of 24 serial bits.
`timescale 1ns/1ps
module mfh_tape_model (
	input wire logic start,
	input wire logic [23:0] bits,
	output logic tape_clock,
	output logic tape_serial_bit,
	output logic busy
);
	initial begin
		tape_clock = 1'b0;
		tape_serial_bit = 1'b0;
		busy = 1'b0;
	end
	// The clock stands low between frames; data shows its inverse when idle.
	always @(posedge start) begin : frame
		int i;
		busy = 1'b1;
		for (i = 0; i < 24; i++) begin
			tape_serial_bit = bits[i];
			#37;
			tape_clock = 1'b1;
			#160;
			tape_clock = 1'b0;
			tape_serial_bit = ~bits[i];
			#123;
		end
		busy = 1'b0;
	end
endmodule : mfh_tape_model

// ==== mfh_core_tb.sv ====
// Self-checking bench for the micro fetch/hold control.
`timescale 1ns/1ps
module mfh_core_tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd, mar, lat;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic micro_finish = 1'b0, arith_overflow = 1'b0, arith_underflow = 1'b0;
	logic refresh_request = 1'b0, step_button_pressed = 1'b0;
	logic clear_button = 1'b0, tape_start = 1'b0, seen_stored = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, tape_clock, tape_serial_bit, tape_busy;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [23:0] tape_bits = 24'h0;
	logic [15:0] micro_bus, key_byte_address_bits;
	logic hold_flag_clear, next_micro_fetch_enable, assembly_not_full;
	logic incoming_bit_stored, incoming_bit_shift_in, incdec_test_decode;
	logic skip_next_micro, step_address_pulse, clear_inhibit, halted;
	logic general_processor_clear, refresh_granted, hold_refresh_demand;
	logic no_jump, micro_half_select;
	integer seed = 71;
	int err_count = 0, n_checks = 0, shifts = 0, i;
	mfh_core dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .micro_finish, .arith_overflow, .arith_underflow,
		.refresh_request, .tape_clock, .tape_serial_bit,
		.step_button_pressed, .clear_button, .micro_bus, .hold_flag_clear,
		.next_micro_fetch_enable, .assembly_not_full, .incoming_bit_stored,
		.incoming_bit_shift_in, .incdec_test_decode, .skip_next_micro,
		.step_address_pulse, .clear_inhibit, .general_processor_clear,
		.refresh_granted, .hold_refresh_demand, .no_jump, .halted,
		.key_byte_address_bits, .micro_half_select);
	mfh_tape_model tape (.start(tape_start), .bits(tape_bits), .tape_clock,
		.tape_serial_bit, .busy(tape_busy));
	always #20 aclk = ~aclk;
	always @(posedge aclk) begin
		if (incoming_bit_shift_in) shifts <= shifts + 1;
		if (incoming_bit_stored) seen_stored <= 1'b1;
	end
	function automatic logic [31:0] half_of(logic [31:0] w, logic [31:0] a);
		return a[4] ? {16'h0, w[31:16]} : {16'h0, w[15:0]};
	endfunction : half_of
	function automatic logic [31:0] rev24(logic [23:0] b);
		logic [31:0] r;
		r = 32'h0;
		for (int k = 0; k < 24; k++) r[23-k] = b[k];
		return r;
	endfunction : rev24
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
		n_checks++;
		if (seen !== ex) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, ex, seen);
		end
	endtask : chk
	task report_and_stop();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : report_and_stop
	task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ad, wd, b;
		@(posedge aclk);
		ad = 1'b0;
		wd = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge aclk);
			ad = ad | (s_axi_awvalid & s_axi_awready);
			wd = wd | (s_axi_wvalid & s_axi_wready);
			b = s_axi_bvalid;
			rs = s_axi_bresp;
			@(posedge aclk);
			if (ad) s_axi_awvalid <= 1'b0;
			if (wd) s_axi_wvalid <= 1'b0;
		end while (!b);
		s_axi_bready <= 1'b0;
		chk("bresp", {30'h0, rs}, {30'h0, er});
	endtask : axw
	task axr(input logic [7:0] a, output logic [31:0] d);
		logic t;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge aclk);
			t = s_axi_arvalid & s_axi_arready;
			@(posedge aclk);
		end while (!t);
		s_axi_arvalid <= 1'b0;
		do begin
			@(negedge aclk);
			t = s_axi_rvalid;
			d = s_axi_rdata;
			rs = s_axi_rresp;
			@(posedge aclk);
		end while (!t);
		s_axi_rready <= 1'b0;
	endtask : axr
	task finish_once();
		micro_finish <= 1'b1;
		@(posedge aclk);
		micro_finish <= 1'b0;
		repeat (3) @(posedge aclk);
	endtask : finish_once
	task send_frame();
		tape_start <= 1'b1;
		@(posedge aclk);
		tape_start <= 1'b0;
		@(negedge tape_busy);
		repeat (8) @(posedge aclk);
	endtask : send_frame
	initial begin
		#2000000;
		err_count++;
		report_and_stop();
	end
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk("hold rst", hold_flag_clear, 1'b1);
		lat = $random(seed);
		axw(mfh_pkg::REG_LATCH, lat, mfh_pkg::AXI_OKAY);
		for (i = 0; i < 4; i++) begin
			axr(mfh_pkg::REG_MAR, mar);
			finish_once();
			axr(mfh_pkg::REG_MAR, rd);
			chk("mar up", rd, mar + 32'h10);
			chk("half", {31'h0, rd[4]}, {31'h0, ~mar[4]});
			chk("bus", {16'h0, micro_bus}, half_of(lat, rd));
			chk("kba", {16'h0, key_byte_address_bits}, rd[18:3]);
		end
		for (i = 1; i < 4; i += 2) begin
			axw(mfh_pkg::REG_CTRL, i, mfh_pkg::AXI_OKAY);
			repeat (2) @(posedge aclk);
			chk("hold set", hold_flag_clear, 1'b0);
			finish_once();
			chk("nop bus", {16'h0, micro_bus}, 32'h0);
			axr(mfh_pkg::REG_MAR, rd);
			chk("mar held", rd, mar + 32'h10);
		end
		axw(mfh_pkg::REG_CTRL, 32'h0, mfh_pkg::AXI_OKAY);
		tape_bits = 24'($random(seed)) | 24'h1;
		send_frame();
		chk("stored", seen_stored, 1'b1);
		chk("shifted", shifts != 0, 1'b1);
		chk("full", assembly_not_full, 1'b0);
		axr(mfh_pkg::REG_TAPE, rd);
		chk("count", rd[28:24], mfh_pkg::ASM_FULL_COUNT);
		chk("tape data", {8'h00, rd[23:0]}, rev24(tape_bits));
		finish_once();
		axr(mfh_pkg::REG_MAR, rd);
		chk("mar full", rd, mar + 32'h10);
		axw(mfh_pkg::REG_CTRL, 32'h4, mfh_pkg::AXI_OKAY);
		axw(mfh_pkg::REG_TAPE, 32'h0, mfh_pkg::AXI_OKAY);
		chk("emptied", assembly_not_full, 1'b1);
		shifts = 0;
		send_frame();
		chk("no shift", shifts, 0);
		axw(mfh_pkg::REG_TAPE, 32'h0, mfh_pkg::AXI_OKAY);
		axw(mfh_pkg::REG_CTRL, 32'h0, mfh_pkg::AXI_OKAY);
		axw(mfh_pkg::REG_LATCH, 32'h3C023C01, mfh_pkg::AXI_OKAY);
		repeat (300) begin
			@(posedge aclk);
			micro_finish <= 1'($random(seed));
			arith_overflow <= 1'($random(seed));
			arith_underflow <= 1'($random(seed));
			refresh_request <= 1'($random(seed));
		end
		{micro_finish, arith_overflow, arith_underflow, refresh_request} <= 4'h0;
		repeat (4) @(posedge aclk);
		axw(mfh_pkg::REG_CTRL, 32'h8, mfh_pkg::AXI_OKAY);
		// A skip left armed by the random run spends the first finish.
		finish_once();
		finish_once();
		chk("halted", halted, 1'b1);
		axr(mfh_pkg::REG_MAR, mar);
		for (i = 0; i < 2; i++) begin
			step_button_pressed <= 1'b1;
			repeat (30) @(posedge aclk);
			step_button_pressed <= 1'b0;
			repeat (10) @(posedge aclk);
		end
		axr(mfh_pkg::REG_MAR, rd);
		chk("step", rd, (mar + 32'h20) & 32'hFFFFFF);
		clear_button <= 1'b1;
		repeat (8) @(posedge aclk);
		clear_button <= 1'b0;
		axr(mfh_pkg::REG_MAR, rd);
		chk("cleared", rd, 32'h0);
		refresh_request <= 1'b1;
		finish_once();
		axw(mfh_pkg::REG_CTRL, 32'h10, mfh_pkg::AXI_OKAY);
		axr(mfh_pkg::REG_STATUS, rd);
		chk("clr held", {30'h0, rd[7], rd[4]}, 32'h3);
		refresh_request <= 1'b0;
		axw(mfh_pkg::REG_CTRL, 32'h0, mfh_pkg::AXI_OKAY);
		repeat (3) @(posedge aclk);
		step_button_pressed <= 1'b1;
		repeat (20) @(posedge aclk);
		step_button_pressed <= 1'b0;
		axr(mfh_pkg::REG_MAR, rd);
		chk("run step", rd, 32'h0);
		axr(8'h20, rd);
		chk("unmapped", {rs, rd[29:0]}, {mfh_pkg::AXI_SLVERR, 30'h0});
		axw(8'h24, 32'h1, mfh_pkg::AXI_SLVERR);
		report_and_stop();
	end
endmodule : mfh_core_tb
